/* rtl/sensor_port_pkg.sv */
// constants, register map and carrier types of the sensor serial port controller
package sensor_port_pkg;

   // system clock rate
   localparam int CLK_MHZ = 200;

   // serial timing, in the printed units
   localparam int T_SRAD_US = 4;
   localparam int T_SWW_US = 30;
   localparam int T_SWR_US = 20;
   localparam int T_SRR_NS = 500;
   localparam int T_BEXIT_NS = 500;
   localparam int T_CS_SCLK_NS = 120;
   localparam int T_SCLK_CS_RD_NS = 120;
   localparam int T_SCLK_CS_WR_US = 20;

   // the same times as clock cycles, least times rounded up
   localparam int SRAD_CYC = T_SRAD_US * CLK_MHZ;
   localparam int SWW_CYC = T_SWW_US * CLK_MHZ;
   localparam int SWR_CYC = T_SWR_US * CLK_MHZ;
   localparam int SRR_CYC = (T_SRR_NS * CLK_MHZ + 999) / 1000;
   localparam int BEXIT_CYC = (T_BEXIT_NS * CLK_MHZ + 999) / 1000;
   localparam int CS_SCLK_CYC = (T_CS_SCLK_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_HOLD_CYC = (T_SCLK_CS_RD_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_HOLD_CYC = T_SCLK_CS_WR_US * CLK_MHZ;

   // device register addresses
   localparam logic [6:0] DEV_MOVEMENT_STATUS = 7'h02;
   localparam logic [6:0] DEV_X_DISP_LOW = 7'h03;
   localparam logic [6:0] DEV_Y_DISP_LOW = 7'h04;
   localparam logic [6:0] DEV_XY_DISP_HIGH = 7'h05;
   localparam logic [6:0] DEV_INIT_TUNING_A = 7'h21;
   localparam logic [6:0] DEV_INIT_TUNING_B = 7'h22;
   localparam logic [6:0] DEV_INIT_TUNING_C = 7'h23;
   localparam logic [6:0] DEV_HEALTH_FLAGS = 7'h2e;
   localparam logic [6:0] DEV_STARTUP_RESET_CMD = 7'h3a;
   localparam logic [6:0] DEV_SLEEP_CMD = 7'h3b;
   localparam logic [6:0] DEV_INIT_PAGE_SELECT = 7'h3c;
   localparam logic [6:0] DEV_BURST_REPORT = 7'h42;

   // command values
   localparam logic [7:0] STARTUP_KEY = 8'h5a;
   localparam logic [7:0] SLEEP_KEY = 8'he7;
   localparam logic [3:0] HEALTH_OK = 4'hf;
   localparam int BURST_MAX = 8;
   localparam logic [2:0] BURST_MIN_M1 = 3'h1;

   // controller registers, byte offsets on the bus
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_CTRL = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_BURST_LO = 5'h0c;
   localparam logic [4:0] REG_BURST_HI = 5'h10;
   localparam logic [4:0] REG_INIT_DATA = 5'h14;

   // command and control register fields
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_WRITE_BIT = 15;
   localparam int CMD_LEN_LSB = 16;
   localparam int CMD_BURST_BIT = 19;
   localparam int CTRL_INIT_BIT = 0;
   localparam int CTRL_WAKE_BIT = 1;
   localparam int CTRL_ABORT_BIT = 2;

   typedef enum logic [1:0] {
      XF_WRITE = 2'h0,
      XF_READ = 2'h1,
      XF_BURST = 2'h2,
      XF_PULSE = 2'h3
   } xfer_kind_t;

   typedef struct packed {
      xfer_kind_t kind;
      logic [6:0] addr;
      logic [7:0] data;
      logic [2:0] len_m1;
   } xfer_req_t;

   typedef enum logic [2:0] {
      OP_PULSE = 3'h0,
      OP_WRITE = 3'h1,
      OP_FRAME = 3'h2,
      OP_CHECK = 3'h3,
      OP_READ = 3'h4,
      OP_END = 3'h5
   } seq_op_t;

   typedef struct packed {
      seq_op_t op;
      logic [6:0] addr;
      logic [7:0] data;
   } seq_step_t;

   localparam logic [4:0] SEQ_WAKE_START = 5'h01;
   localparam logic [4:0] SEQ_READ_FIRST = 5'h06;
   localparam logic [4:0] SEQ_READ_LAST = 5'h09;

endpackage

/* rtl/sensor_serial_port_ctrl.sv */
// host controller for the motion sensor four-wire serial port
//
// Added by the designer: the Avalon-MM interface to the registers.

// Summary of operation
// - only this controller starts transfers, makes clock
// - after abort, wait full gap before next
// - frame every transaction with select, idle high
// - write: 1 plus address, then data byte
// - read: 0 plus address, device returns data
// - space writes by the write-write gap
// - space write then read by write-read gap (code waits the full write-write gap after every write)
// - wait address-data delay before read data
// - wait read-next gap after a read
// - burst ends after X byte or later
// - raise select for burst exit time
// - power-up: pulse select, write reset key
// - frame wait, clear flags, check bits 0-3
// - read registers 0x02 to 0x05 once
// - six tuning writes in fixed order
// - wake: reset key, checks, tuning writes
// - address-data delay is 4 microseconds
// - write-write gap is 30 microseconds
// - write-read gap is 20 microseconds
// - burst exit time is 500 nanoseconds
module sensor_serial_port_ctrl
   import sensor_port_pkg::*;
#(
   parameter int HALF_CYC = 100,
   parameter int FRAME_CYC = 200000,
   parameter int SWW_CYCLES = SWW_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic sclk,
   output logic chip_select_n,
   output logic mosi,
   input wire logic miso
);

   typedef enum logic [2:0] {
      E_IDLE = 3'b000,
      E_SETUP = 3'b001,
      E_ADDR = 3'b011,
      E_SRAD = 3'b010,
      E_DATA = 3'b110,
      E_HOLD = 3'b111,
      E_GAP = 3'b101
   } eng_state_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ISSUE = 2'b01,
      S_WAIT = 2'b11,
      S_FRAME = 2'b10
   } seq_state_t;

   localparam int TW = 18;

   function automatic logic [TW-1:0] cyc(input int n);
      cyc = TW'(n - 1);
   endfunction

   function automatic seq_step_t seq_rom(input logic [4:0] idx);
      unique case (idx)
         5'h00: seq_rom = '{OP_PULSE, 7'h00, 8'h00};
         5'h01: seq_rom = '{OP_WRITE, DEV_STARTUP_RESET_CMD, STARTUP_KEY};
         5'h02: seq_rom = '{OP_FRAME, 7'h00, 8'h00};
         5'h03: seq_rom = '{OP_WRITE, DEV_HEALTH_FLAGS, 8'h00};
         5'h04: seq_rom = '{OP_FRAME, 7'h00, 8'h00};
         5'h05: seq_rom = '{OP_CHECK, DEV_HEALTH_FLAGS, 8'h00};
         5'h06: seq_rom = '{OP_READ, DEV_MOVEMENT_STATUS, 8'h00};
         5'h07: seq_rom = '{OP_READ, DEV_X_DISP_LOW, 8'h00};
         5'h08: seq_rom = '{OP_READ, DEV_Y_DISP_LOW, 8'h00};
         5'h09: seq_rom = '{OP_READ, DEV_XY_DISP_HIGH, 8'h00};
         5'h0a: seq_rom = '{OP_WRITE, DEV_INIT_PAGE_SELECT, 8'h27};
         5'h0b: seq_rom = '{OP_WRITE, DEV_INIT_TUNING_B, 8'h0a};
         5'h0c: seq_rom = '{OP_WRITE, DEV_INIT_TUNING_A, 8'h01};
         5'h0d: seq_rom = '{OP_WRITE, DEV_INIT_PAGE_SELECT, 8'h32};
         5'h0e: seq_rom = '{OP_WRITE, DEV_INIT_TUNING_C, 8'h20};
         5'h0f: seq_rom = '{OP_WRITE, DEV_INIT_PAGE_SELECT, 8'h05};
         default: seq_rom = '{OP_END, 7'h00, 8'h00};
      endcase
   endfunction

   // engine state
   eng_state_t eng_reg;
   logic [TW-1:0] timer_reg;
   logic phase_reg;
   logic [2:0] bit_reg;
   logic [2:0] byte_reg;
   logic [7:0] shift_reg;
   xfer_req_t cur_reg;
   logic eng_done_reg;
   logic [7:0] rd_byte_reg;
   logic [7:0] burst_mem [BURST_MAX];
   // requesters
   xfer_req_t sw_req_reg;
   logic sw_valid_reg;
   xfer_req_t seq_req_reg;
   logic seq_valid_reg;
   seq_state_t seq_reg;
   logic [4:0] step_reg;
   logic wake_reg;
   logic [TW-1:0] frame_reg;
   logic [31:0] init_data_reg;
   logic init_ok_reg;
   logic init_fail_reg;
   logic sleeping_reg;
   logic refused_reg;
   logic miso_meta_reg;
   logic miso_sync_reg;
   logic abort_reg;
   logic init_go_reg;
   logic wake_go_reg;

   logic bus_req;
   logic bus_wr;
   logic bus_rd;
   logic eng_take;
   logic take_seq;
   logic busy;
   logic cmd_ok;
   logic last_bit;
   xfer_req_t next_req;
   xfer_req_t cmd_req;
   seq_step_t step;

   assign bus_req = (read | write) & ~waitrequest;
   assign bus_wr = write & ~waitrequest;
   assign bus_rd = read & ~waitrequest;
   assign take_seq = seq_valid_reg;
   assign next_req = take_seq ? seq_req_reg : sw_req_reg;
   assign eng_take = (eng_reg == E_IDLE) & (seq_valid_reg | sw_valid_reg)
                     & ~abort_reg;
   assign busy = (eng_reg != E_IDLE) | sw_valid_reg | (seq_reg != S_IDLE);
   assign last_bit = (bit_reg == 3'h7);
   assign step = seq_rom(step_reg);

   always_comb begin
      cmd_req.kind = writedata[CMD_BURST_BIT] ? XF_BURST :
                     (writedata[CMD_WRITE_BIT] ? XF_WRITE : XF_READ);
      cmd_req.addr = writedata[CMD_ADDR_LSB +: 7];
      cmd_req.data = writedata[7:0];
      cmd_req.len_m1 = writedata[CMD_LEN_LSB +: 3];
      if (writedata[CMD_BURST_BIT]) begin
         cmd_req.addr = DEV_BURST_REPORT;
         if (writedata[CMD_LEN_LSB +: 3] < BURST_MIN_M1) begin
            cmd_req.len_m1 = BURST_MIN_M1;
         end
      end
      // while asleep only the startup key may pass
      cmd_ok = ~sleeping_reg | (cmd_req.kind == XF_WRITE
               && cmd_req.addr == DEV_STARTUP_RESET_CMD
               && cmd_req.data == STARTUP_KEY);
   end

   // input synchroniser for the data line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         miso_meta_reg <= 1'b0;
         miso_sync_reg <= 1'b0;
      end else begin
         miso_meta_reg <= miso;
         miso_sync_reg <= miso_meta_reg;
      end
   end

   // bus slave: one wait cycle, then the answer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if ((read | write) & waitrequest) begin
            unique case (address)
               REG_STATUS: readdata <= {16'h0, rd_byte_reg, 2'h0,
                  refused_reg, init_fail_reg, init_ok_reg,
                  sleeping_reg, seq_reg != S_IDLE, busy};
               REG_BURST_LO: readdata <= {burst_mem[3], burst_mem[2],
                  burst_mem[1], burst_mem[0]};
               REG_BURST_HI: readdata <= {burst_mem[7], burst_mem[6],
                  burst_mem[5], burst_mem[4]};
               REG_INIT_DATA: readdata <= init_data_reg;
               REG_CMD: readdata <= {12'h0, sw_req_reg.kind == XF_BURST,
                  sw_req_reg.len_m1, sw_req_reg.kind == XF_WRITE,
                  sw_req_reg.addr, sw_req_reg.data};
               default: readdata <= 32'h0;
            endcase
         end
      end
   end

   // control pulses from the control register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         abort_reg <= 1'b0;
         init_go_reg <= 1'b0;
         wake_go_reg <= 1'b0;
      end else begin
         abort_reg <= 1'b0;
         init_go_reg <= 1'b0;
         wake_go_reg <= 1'b0;
         if (bus_wr && address == REG_CTRL && byteenable[0]) begin
            abort_reg <= writedata[CTRL_ABORT_BIT];
            init_go_reg <= writedata[CTRL_INIT_BIT] & ~busy;
            wake_go_reg <= writedata[CTRL_WAKE_BIT] & ~busy
                           & ~writedata[CTRL_INIT_BIT];
         end
      end
   end

   // software command slot
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_req_reg <= '0;
         sw_valid_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         if (eng_take && !take_seq) begin
            sw_valid_reg <= 1'b0;
         end
         if (abort_reg) begin
            sw_valid_reg <= 1'b0;
         end
         if (bus_wr && address == REG_CMD) begin
            if (byteenable == 4'hf && !busy && cmd_ok) begin
               sw_req_reg <= cmd_req;
               sw_valid_reg <= 1'b1;
               refused_reg <= 1'b0;
            end else begin
               refused_reg <= 1'b1;
            end
         end
      end
   end

   // power-up and wake sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_reg <= S_IDLE;
         step_reg <= 5'h0;
         wake_reg <= 1'b0;
         frame_reg <= '0;
         seq_req_reg <= '0;
         seq_valid_reg <= 1'b0;
         init_data_reg <= 32'h0;
         init_ok_reg <= 1'b0;
         init_fail_reg <= 1'b0;
      end else if (abort_reg) begin
         seq_reg <= S_IDLE;
         seq_valid_reg <= 1'b0;
      end else begin
         if (eng_take && take_seq) begin
            seq_valid_reg <= 1'b0;
         end
         unique case (seq_reg)
            S_IDLE: begin
               if (init_go_reg || wake_go_reg) begin
                  // wake skips the select pulse and starts at the key write
                  step_reg <= init_go_reg ? 5'h0 : SEQ_WAKE_START;
                  wake_reg <= wake_go_reg;
                  init_ok_reg <= 1'b0;
                  init_fail_reg <= 1'b0;
                  seq_reg <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               if (wake_reg && step_reg >= SEQ_READ_FIRST
                   && step_reg <= SEQ_READ_LAST) begin
                  step_reg <= step_reg + 5'h1;
               end else begin
                  unique case (step.op)
                     OP_END: begin
                        init_ok_reg <= 1'b1;
                        seq_reg <= S_IDLE;
                     end
                     OP_FRAME: begin
                        frame_reg <= cyc(FRAME_CYC);
                        seq_reg <= S_FRAME;
                     end
                     default: begin
                        seq_req_reg.kind <= (step.op == OP_PULSE) ? XF_PULSE
                           : (step.op == OP_WRITE ? XF_WRITE : XF_READ);
                        seq_req_reg.addr <= step.addr;
                        seq_req_reg.data <= step.data;
                        seq_req_reg.len_m1 <= 3'h0;
                        seq_valid_reg <= 1'b1;
                        seq_reg <= S_WAIT;
                     end
                  endcase
               end
            end
            S_WAIT: begin
               if (eng_done_reg) begin
                  step_reg <= step_reg + 5'h1;
                  seq_reg <= S_ISSUE;
                  if (step.op == OP_CHECK
                      && rd_byte_reg[3:0] != HEALTH_OK) begin
                     init_fail_reg <= 1'b1;
                     seq_reg <= S_IDLE;
                  end
                  if (step.op == OP_READ) begin
                     init_data_reg[8*(step_reg-SEQ_READ_FIRST) +: 8]
                        <= rd_byte_reg;
                  end
               end
            end
            S_FRAME: begin
               if (frame_reg == '0) begin
                  step_reg <= step_reg + 5'h1;
                  seq_reg <= S_ISSUE;
               end else begin
                  frame_reg <= frame_reg - TW'(1);
               end
            end
         endcase
      end
   end

   // shutdown tracking from completed writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleeping_reg <= 1'b0;
      end else if (eng_done_reg && cur_reg.kind == XF_WRITE) begin
         if (cur_reg.addr == DEV_SLEEP_CMD && cur_reg.data == SLEEP_KEY) begin
            sleeping_reg <= 1'b1;
         end else if (cur_reg.addr == DEV_STARTUP_RESET_CMD
                      && cur_reg.data == STARTUP_KEY) begin
            sleeping_reg <= 1'b0;
         end
      end
   end

   // serial engine: clock idles high, select idles high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         eng_reg <= E_IDLE;
         timer_reg <= '0;
         phase_reg <= 1'b0;
         bit_reg <= 3'h0;
         byte_reg <= 3'h0;
         shift_reg <= 8'h0;
         cur_reg <= '0;
         eng_done_reg <= 1'b0;
         rd_byte_reg <= 8'h0;
         burst_mem <= '{default: 8'h00};
         sclk <= 1'b1;
         chip_select_n <= 1'b1;
         mosi <= 1'b0;
      end else begin
         eng_done_reg <= 1'b0;
         if (abort_reg && eng_reg != E_IDLE && eng_reg != E_GAP) begin
            // the device drops the partial transaction
            chip_select_n <= 1'b1;
            sclk <= 1'b1;
            timer_reg <= cyc(SWW_CYCLES);
            eng_reg <= E_GAP;
         end else if (eng_reg != E_IDLE && timer_reg != '0) begin
            timer_reg <= timer_reg - TW'(1);
         end else begin
            unique case (eng_reg)
               E_IDLE: begin
                  if (eng_take) begin
                     cur_reg <= next_req;
                     chip_select_n <= 1'b0;
                     timer_reg <= cyc(CS_SCLK_CYC);
                     eng_reg <= E_SETUP;
                  end
               end
               E_SETUP: begin
                  if (cur_reg.kind == XF_PULSE) begin
                     chip_select_n <= 1'b1;
                     timer_reg <= cyc(BEXIT_CYC);
                     eng_reg <= E_GAP;
                  end else begin
                     // msb of the address byte is the direction
                     shift_reg <= {cur_reg.kind == XF_WRITE, cur_reg.addr};
                     mosi <= (cur_reg.kind == XF_WRITE);
                     sclk <= 1'b0;
                     phase_reg <= 1'b0;
                     bit_reg <= 3'h0;
                     byte_reg <= 3'h0;
                     timer_reg <= cyc(HALF_CYC);
                     eng_reg <= E_ADDR;
                  end
               end
               E_ADDR, E_DATA: begin
                  if (!phase_reg) begin
                     sclk <= 1'b1;
                     phase_reg <= 1'b1;
                     timer_reg <= cyc(HALF_CYC);
                  end else if (!last_bit) begin
                     // device changed its bit at our falling edge
                     shift_reg <= {shift_reg[6:0], miso_sync_reg};
                     mosi <= shift_reg[6];
                     sclk <= 1'b0;
                     phase_reg <= 1'b0;
                     bit_reg <= bit_reg + 3'h1;
                     timer_reg <= cyc(HALF_CYC);
                  end else if (eng_reg == E_ADDR) begin
                     bit_reg <= 3'h0;
                     phase_reg <= 1'b0;
                     if (cur_reg.kind == XF_WRITE) begin
                        shift_reg <= cur_reg.data;
                        mosi <= cur_reg.data[7];
                        sclk <= 1'b0;
                        timer_reg <= cyc(HALF_CYC);
                        eng_reg <= E_DATA;
                     end else begin
                        timer_reg <= cyc(SRAD_CYC);
                        eng_reg <= E_SRAD;
                     end
                  end else begin
                     rd_byte_reg <= {shift_reg[6:0], miso_sync_reg};
                     burst_mem[byte_reg] <= {shift_reg[6:0], miso_sync_reg};
                     bit_reg <= 3'h0;
                     phase_reg <= 1'b0;
                     if (cur_reg.kind == XF_BURST
                         && byte_reg != cur_reg.len_m1) begin
                        // next burst byte follows with no pause
                        byte_reg <= byte_reg + 3'h1;
                        shift_reg <= 8'h0;
                        mosi <= 1'b0;
                        sclk <= 1'b0;
                        timer_reg <= cyc(HALF_CYC);
                     end else begin
                        timer_reg <= (cur_reg.kind == XF_WRITE) ?
                           cyc(WR_HOLD_CYC) : cyc(RD_HOLD_CYC);
                        eng_reg <= E_HOLD;
                     end
                  end
               end
               E_SRAD: begin
                  shift_reg <= 8'h0;
                  mosi <= 1'b0;
                  sclk <= 1'b0;
                  timer_reg <= cyc(HALF_CYC);
                  eng_reg <= E_DATA;
               end
               E_HOLD: begin
                  chip_select_n <= 1'b1;
                  unique case (cur_reg.kind)
                     XF_WRITE: timer_reg <= 
                        cyc(SWW_CYCLES - WR_HOLD_CYC);
                     XF_BURST: timer_reg <= cyc(BEXIT_CYC);
                     default: timer_reg <= cyc(SRR_CYC);
                  endcase
                  eng_reg <= E_GAP;
               end
               E_GAP: begin
                  eng_done_reg <= 1'b1;
                  eng_reg <= E_IDLE;
               end
               default: eng_reg <= E_IDLE;
            endcase
         end
      end
   end

endmodule // sensor_serial_port_ctrl

/* sim/sensor_serial_port_ctrl_monitor.sv */
// timing checker for the sensor port controller
module sensor_serial_port_ctrl_monitor #(
   parameter int HALF_CYC = 100
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic mosi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] lo_cnt, hs_cnt, hi_cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lo_cnt <= 16'h0;
         hs_cnt <= 16'h0;
         hi_cnt <= 16'h00ff;
      end else begin
         lo_cnt <= sclk ? 16'h0 : lo_cnt + 16'h1;
         hs_cnt <= (sclk && !chip_select_n) ? hs_cnt + 16'h1 : 16'h0;
         hi_cnt <= chip_select_n ? hi_cnt + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_wait;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not one cycle");
   property p_idle;
      chip_select_n |-> sclk;
   endproperty
   a_idle: assert property (p_idle) else $error("clock while idle");
   property p_mosi;
      $changed(mosi) |-> $fell(sclk);
   endproperty
   a_mosi: assert property (p_mosi) else $error("mosi moved");
   property p_low;
      $rose(sclk) && !chip_select_n |-> lo_cnt == 16'(HALF_CYC);
   endproperty
   a_low: assert property (p_low) else $error("low half wrong");
   property p_high;
      $fell(sclk) |-> hs_cnt >= 16'(HALF_CYC)
         && !(hs_cnt > 16'd30 && hs_cnt < 16'd800);
   endproperty
   a_high: assert property (p_high) else $error("high gap");
   property p_gap;
      $fell(chip_select_n) |-> hi_cnt >= 16'd100;
   endproperty
   a_gap: assert property (p_gap) else $error("select gap");
   property p_frame;
      $fell(chip_select_n) |-> !chip_select_n [*8];
   endproperty
   a_frame: assert property (p_frame) else $error("short frame");
   property p_unmap;
      read && !waitrequest && address == 5'h18 |-> readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   c_srad: cover property (hs_cnt == 16'd800);
   c_end: cover property ($rose(chip_select_n));
   c_rd: cover property (read && !waitrequest);
endmodule // sensor_serial_port_ctrl_monitor
bind sensor_serial_port_ctrl sensor_serial_port_ctrl_monitor #(
   .HALF_CYC(HALF_CYC)) u_mon (.clk(clk), .rst_b(rst_b),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .sclk(sclk),
   .chip_select_n(chip_select_n), .mosi(mosi));

/* sim/sensor_dev_model.sv */
// behavioural sensor at the far end of the serial port
module sensor_dev_model (
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic mosi,
   output logic miso,
   output logic [14:0] last_wr,
   output int writes
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   logic [6:0] ad;
   logic rd = 0, wr = 0, bit_q = 0, asleep = 0;
   logic [63:0] out;
   int n = 0;
   initial writes = 0;
   initial last_wr = 15'h0;
   // released line shows the inverse of the last bit
   assign miso = chip_select_n ? ~bit_q : bit_q;
   always @(posedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         n = 0;
         rd = 0;
      end else begin
         sh = {sh[6:0], mosi};
         n = n + 1;
         if (n == 8) begin
            ad = sh[6:0];
            wr = sh[7];
            rd = !sh[7] && !asleep;
            out = ad == 7'h42 ? 64'h1122334455667788 :
               {ad == 7'h2e ? 8'h0f : {1'b1, ad}, 56'h0};
         end
         if (n == 16 && wr && (!asleep || {ad, sh} == 15'h3a5a)) begin
            last_wr = {ad, sh};
            writes++;
            asleep = {ad, sh} == 15'h3be7;
         end
      end
   end
   always @(negedge sclk) begin
      if (!chip_select_n && rd && n >= 8) begin
         bit_q = out[63];
         out = out << 1;
      end
   end
endmodule // sensor_dev_model

/* sim/sensor_serial_port_ctrl_tb.sv */
// self-checking bench for the sensor port controller
module sensor_serial_port_ctrl_tb
   import sensor_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, read = 0, write = 0;
   logic [4:0] address = 5'h0;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic waitrequest, sclk, chip_select_n, mosi, miso;
   logic [14:0] last_wr;
   int writes, w0, miscompares = 0, checks_done = 0, cycles = 0;
   always #2.5 clk = ~clk;
   sensor_serial_port_ctrl #(.HALF_CYC(4), .FRAME_CYC(50)) dut (
      .clk(clk), .rst_b(rst_b), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hf),
      .readdata(readdata), .waitrequest(waitrequest), .sclk(sclk),
      .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso));
   sensor_dev_model dev (.sclk(sclk), .chip_select_n(chip_select_n),
      .mosi(mosi), .miso(miso), .last_wr(last_wr), .writes(writes));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a,
         input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic idle();
      do bus(1'b0, REG_STATUS, 32'h0); while (q[1:0] !== 2'b00);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_rw();
      bus(1'b1, REG_CMD, 32'h0000a1a5);
      idle();
      chk({17'h0, last_wr}, 32'h21a5);
      bus(1'b1, REG_CMD, 32'h00001000);
      idle();
      chk({24'h0, q[15:8]}, 32'h90);
      bus(1'b0, 5'h18, 32'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_burst();
      bus(1'b1, REG_CMD, 32'h00080000);
      idle();
      bus(1'b0, REG_BURST_LO, 32'h0);
      chk({16'h0, q[15:0]}, 32'h2211);
      bus(1'b1, REG_CMD, 32'h000f0000);
      idle();
      bus(1'b0, REG_BURST_LO, 32'h0);
      chk(q, 32'h44332211);
      bus(1'b0, REG_BURST_HI, 32'h0);
      chk(q, 32'h88776655);
   endtask
   task automatic t_abort();
      w0 = writes;
      bus(1'b1, REG_CMD, 32'h0000a13c);
      repeat (40) @(posedge clk);
      bus(1'b1, REG_CTRL, 32'h4);
      @(posedge clk);
      chk({31'h0, chip_select_n}, 32'h1);
      idle();
      chk(32'(writes - w0), 32'h0);
   endtask
   task automatic t_sleep_init();
      bus(1'b1, REG_CMD, 32'h0000bbe7);
      idle();
      chk({29'h0, q[2:0]}, 32'h4);
      w0 = writes;
      bus(1'b1, REG_CMD, 32'h0000a155);
      bus(1'b0, REG_STATUS, 32'h0);
      chk({26'h0, q[5:0]}, 32'h24);
      bus(1'b1, REG_CTRL, 32'h1);
      idle();
      chk({27'h0, q[4:0]}, 32'h8);
      chk(32'(writes - w0), 32'h8);
      chk({17'h0, last_wr}, 32'h3c05);
      bus(1'b0, REG_INIT_DATA, 32'h0);
      chk(q, 32'h85848382);
   endtask
   task automatic t_wake();
      w0 = writes;
      bus(1'b1, REG_CTRL, 32'h2);
      while (writes == w0) @(posedge clk);
      chk({17'h0, last_wr}, 32'h3a5a);
      repeat (20) @(posedge clk);
      bus(1'b1, REG_CTRL, 32'h4);
      idle();
      chk({27'h0, q[4:0]}, 32'h0);
      chk(32'(writes - w0), 32'h1);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_rw();
      t_burst();
      t_abort();
      t_sleep_init();
      t_wake();
      summarize();
   end
endmodule // sensor_serial_port_ctrl_tb
